// [hdl/lin_flags_map.svh]
// offsets, field positions, reset values and timing counts of the link status block
// What this block does
// - frame-error flag set on missing stop bit, cleared by status read
// - count falling edges since the last break; flag error at 57 or more, read clears
// - own transmission aborted on collision sets collision flag, read clears
// - no collision flag when combined option selected and transmit-complete already set
// - bus low for 11 bit times sets break flag, read clears
// - transmit-complete low while data pending, high when sent, cleared by break/receive
// - transmit-ready low until written byte moves into shift register
// - data write while transmit-ready low replaces pending byte
// - receive-ready set on new byte, cleared by data register read
// - lot word: wafer number 31:27, plant 26:22, lot id 21:0
// - revision word bits 31:28 hold mask revision 1 to 15
// - revision word bits 27:20 hold kernel ASCII code, 19:16 reserved
// - revision word low 16 bits hold part id number
// - flash address register 16 bits, family id in 3:0 at reset
// - software sets transmit mode bit; device clears it on break
`ifndef LIN_FLAGS_MAP_SVH
`define LIN_FLAGS_MAP_SVH

// register byte addresses
`define ADDR_STATUS       32'hFFFF0700
`define ADDR_DATA         32'hFFFF0704
`define ADDR_CONTROL      32'hFFFF0708
`define ADDR_MASK         32'hFFFF070C
`define ADDR_LOT_TRACE    32'hFFFF0710
`define ADDR_REV_TRACE    32'hFFFF0714
`define ADDR_FLASH_ADDR   32'hFFFF0E10

// status field positions
`define ST_FRAME_ERR      6
`define ST_EDGE_ERR       5
`define ST_COLLISION      4
`define ST_BREAK          3
`define ST_TX_DONE        2
`define ST_TX_READY       1
`define ST_RX_READY       0
`define ST_READ_CLEAR     7'h78

// control field positions
`define CTL_MODE          0
`define CTL_SEPARATE      1

// reset values
`define RST_STATUS        7'h02
`define RST_MASK          7'h7F
`define RST_CONTROL       2'h0

// timing
`define CORE_CLK_MHZ      100
`define LINK_BIT_TIME_NS  52083
`define LINK_BIT_CYCLES   ((`LINK_BIT_TIME_NS * `CORE_CLK_MHZ) / 1000)
`define BREAK_BITS        11
`define EDGE_LIMIT        57
`define FRAME_BITS        10

`endif

// [hdl/lin_flags_pkg.sv]
// types shared by the link status block
package lin_flags_pkg;

    typedef struct packed {
        logic frame_err;
        logic edge_err;
        logic collision;
        logic brk;
        logic tx_done;
        logic tx_ready;
        logic rx_ready;
    } status_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tx_state_t;

endpackage

// [hdl/lin_slave_status_flags.sv]
// link slave with status flags, trace words and AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "lin_flags_map.svh"

module lin_slave_status_flags #(
    parameter int          BIT_CYCLES = `LINK_BIT_CYCLES,
    parameter logic [4:0]  WAFER_NUM  = 5'h01,   // arbitrary value
    parameter logic [4:0]  FAB_PLANT  = 5'h01,   // arbitrary value
    parameter logic [21:0] LOT_ID     = 22'h000001, // arbitrary value
    parameter logic [3:0]  MASK_REV   = 4'h1,    // arbitrary value
    parameter logic [7:0]  KERNEL_REV = 8'h41,   // arbitrary value
    parameter logic [15:0] PART_ID    = 16'h0001, // arbitrary value
    parameter logic [3:0]  FAMILY_ID  = 4'h1     // arbitrary value
) (
    input  wire logic                   CORE_CLK,
    input  wire logic                   NRST,
    input  wire logic [31:0]            AWADDR,
    input  wire logic                   AWVALID,
    output logic                        AWREADY,
    input  wire logic [31:0]            WDATA,
    input  wire logic [3:0]             WSTRB,
    input  wire logic                   WVALID,
    output logic                        WREADY,
    output logic [1:0]                  BRESP,
    output logic                        BVALID,
    input  wire logic                   BREADY,
    input  wire logic [31:0]            ARADDR,
    input  wire logic                   ARVALID,
    output logic                        ARREADY,
    output logic [31:0]                 RDATA,
    output logic [1:0]                  RRESP,
    output logic                        RVALID,
    input  wire logic                   RREADY,
    input  wire logic                   LIN_IN,
    output logic                        LIN_OUT,
    output logic                        LIN_OE_N,
    output logic                        IRQ,
    output lin_flags_pkg::status_t      STATUS_FLAGS
);
    import lin_flags_pkg::*;

    localparam int BRK_CYCLES = BIT_CYCLES * `BREAK_BITS;
    localparam int HALF_BIT   = BIT_CYCLES / 2;

    // bus side state
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        aw_held;
    logic        w_held;

    // registers
    status_t     status;
    logic [6:0]  mask;
    logic [1:0]  control;
    logic [15:0] flash_addr;
    logic [7:0]  rx_byte;
    logic [7:0]  tx_hold;
    logic        tx_pending;

    // pin synchroniser
    logic        rx_meta;
    logic        rx_s;
    logic        rx_prev;

    // receiver
    rx_state_t   rx_state;
    logic [15:0] rx_cnt;
    logic [2:0]  rx_bits;
    logic [7:0]  rx_shift;
    logic [19:0] low_cnt;
    logic [5:0]  edge_cnt;

    // transmitter
    tx_state_t   tx_state;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bits;
    logic [9:0]  tx_shift;

    // identity words
    wire [31:0] lot_trace_word = {WAFER_NUM, FAB_PLANT, LOT_ID};
    wire [31:0] revision_part_trace_word = {MASK_REV, KERNEL_REV, 4'h0, PART_ID};

    // bus decode
    wire ar_take  = ARVALID & ARREADY;
    wire do_write = aw_held & w_held & ~BVALID;
    wire wr_data  = do_write & (aw_addr == `ADDR_DATA);
    wire wr_ctl   = do_write & (aw_addr == `ADDR_CONTROL);
    wire wr_mask  = do_write & (aw_addr == `ADDR_MASK);
    wire wr_stat  = do_write & (aw_addr == `ADDR_STATUS);
    wire wr_flash = do_write & (aw_addr == `ADDR_FLASH_ADDR);
    wire wr_ok    = wr_data | wr_ctl | wr_mask | wr_stat | wr_flash;
    wire rd_stat  = ar_take & (ARADDR == `ADDR_STATUS);
    wire rd_data  = ar_take & (ARADDR == `ADDR_DATA);
    wire rd_ok    = rd_stat | rd_data | (ARADDR == `ADDR_CONTROL) | (ARADDR == `ADDR_MASK)
                  | (ARADDR == `ADDR_LOT_TRACE) | (ARADDR == `ADDR_REV_TRACE)
                  | (ARADDR == `ADDR_FLASH_ADDR);
    wire [31:0] rd_word =
          (ARADDR == `ADDR_STATUS)     ? {25'h0, status}
        : (ARADDR == `ADDR_DATA)       ? {24'h0, rx_byte}
        : (ARADDR == `ADDR_CONTROL)    ? {30'h0, control}
        : (ARADDR == `ADDR_MASK)       ? {25'h0, mask}
        : (ARADDR == `ADDR_LOT_TRACE)  ? lot_trace_word
        : (ARADDR == `ADDR_REV_TRACE)  ? revision_part_trace_word
        : (ARADDR == `ADDR_FLASH_ADDR) ? {16'h0, flash_addr}
        : 32'h0;

    // link events
    wire fall       = rx_prev & ~rx_s;
    wire break_hit  = ~rx_s & (low_cnt == 20'(BRK_CYCLES - 1));
    wire rx_sample  = (rx_cnt == 16'h0);
    wire stop_seen  = (rx_state == RX_STOP) & rx_sample;
    wire byte_good  = stop_seen & rx_s;
    wire frame_bad  = stop_seen & ~rx_s;
    wire edge_over  = fall & (edge_cnt >= 6'(`EDGE_LIMIT - 1));
    wire tx_mid     = (tx_state == TX_SEND) & (tx_cnt == 16'(HALF_BIT));
    wire coll_abort = tx_mid & (rx_s != tx_shift[0]);
    wire tx_last    = (tx_state == TX_SEND) & (tx_cnt == 16'h0) & (tx_bits == 4'h0) & ~coll_abort;
    wire tx_load    = (tx_state == TX_IDLE) & control[`CTL_MODE] & tx_pending;
    wire coll_set   = coll_abort & ~(~control[`CTL_SEPARATE] & status.tx_done);
    wire tx_set     = tx_last & ~tx_pending & ~wr_data;

    // flag update: sets win over clears, except a data write, which keeps transmit-complete and transmit-ready low
    wire [6:0] rd_clear = rd_stat ? `ST_READ_CLEAR : 7'h00;
    wire [6:0] w1_clear = (wr_stat & w_strb[0]) ? (w_data[6:0] & `ST_READ_CLEAR) : 7'h00;
    wire [6:0] ev_set   = {frame_bad, edge_over, coll_set, break_hit, 3'b000};
    wire [6:0] sticky   = ({status} & ~(rd_clear | w1_clear)) | ev_set;
    wire next_tx_done   = tx_set ? 1'b1
                        : (break_hit | ~control[`CTL_MODE] | wr_data) ? 1'b0
                        : status.tx_done;
    wire next_rx_ready  = (byte_good & ~control[`CTL_MODE]) | (status.rx_ready & ~rd_data);
    wire next_tx_ready  = ~(wr_data | (tx_pending & ~tx_load));
    wire [6:0] next_status = {sticky[6:3], next_tx_done, next_tx_ready, next_rx_ready};

    // write address and data channels, taken in either order
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            AWREADY <= 1'b1;
            WREADY  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 32'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            BVALID  <= 1'b0;
            BRESP   <= 2'h0;
        end else begin
            if (AWVALID & AWREADY) begin
                aw_addr <= AWADDR;
                aw_held <= 1'b1;
                AWREADY <= 1'b0;
            end
            if (WVALID & WREADY) begin
                w_data <= WDATA;
                w_strb <= WSTRB;
                w_held <= 1'b1;
                WREADY <= 1'b0;
            end
            if (do_write) begin
                BVALID  <= 1'b1;
                BRESP   <= wr_ok ? 2'h0 : 2'h2;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
            if (BVALID & BREADY) begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end

    // read channel, answered the edge the address is taken
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0;
            RRESP   <= 2'h0;
        end else if (ar_take) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_word;
            RRESP   <= rd_ok ? 2'h0 : 2'h2;
        end else if (RVALID & RREADY) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    // software registers
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            status     <= `RST_STATUS;
            mask       <= `RST_MASK;
            control    <= `RST_CONTROL;
            flash_addr <= {12'h000, FAMILY_ID};
            tx_hold    <= 8'h00;
            tx_pending <= 1'b0;
            IRQ        <= 1'b0;
        end else begin
            status <= next_status;
            IRQ    <= |(next_status & ~mask);
            if (wr_mask & w_strb[0])
                mask <= w_data[6:0];
            if (break_hit)
                control[`CTL_MODE] <= 1'b0;
            else if (wr_ctl & w_strb[0])
                control <= w_data[1:0];
            if (wr_flash & w_strb[0])
                flash_addr[7:0] <= w_data[7:0];
            if (wr_flash & w_strb[1])
                flash_addr[15:8] <= w_data[15:8];
            if (wr_data & w_strb[0]) begin
                tx_hold    <= w_data[7:0];
                tx_pending <= 1'b1;
            end else if (tx_load)
                tx_pending <= 1'b0;
        end
    end

    assign STATUS_FLAGS = status;

    // bus pin synchroniser
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_meta <= 1'b1;
            rx_s    <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= LIN_IN;
            rx_s    <= rx_meta;
            rx_prev <= rx_s;
        end
    end

    // low time and falling edge counters
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            low_cnt  <= 20'h0;
            edge_cnt <= 6'h0;
        end else begin
            if (rx_s)
                low_cnt <= 20'h0;
            else if (low_cnt != 20'(BRK_CYCLES))
                low_cnt <= low_cnt + 20'h1;
            if (break_hit)
                edge_cnt <= 6'h0;
            else if (fall & (edge_cnt != 6'h3F))
                edge_cnt <= edge_cnt + 6'h1;
        end
    end

    // byte receiver
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_state <= RX_IDLE;
            rx_cnt   <= 16'h0;
            rx_bits  <= 3'h0;
            rx_shift <= 8'h00;
            rx_byte  <= 8'h00;
        end else begin
            if (!rx_sample)
                rx_cnt <= rx_cnt - 16'h1;
            case (rx_state)
                RX_IDLE: begin
                    if (fall) begin
                        rx_cnt   <= 16'(HALF_BIT);
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_sample) begin
                        rx_cnt   <= 16'(BIT_CYCLES - 1);
                        rx_bits  <= 3'h0;
                        rx_state <= rx_s ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift <= {rx_s, rx_shift[7:1]};
                        rx_bits  <= rx_bits + 3'h1;
                        rx_cnt   <= 16'(BIT_CYCLES - 1);
                        if (rx_bits == 3'h7)
                            rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        if (rx_s & ~control[`CTL_MODE])
                            rx_byte <= rx_shift;
                        rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // byte transmitter with collision check at mid bit
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            tx_state <= TX_IDLE;
            tx_cnt   <= 16'h0;
            tx_bits  <= 4'h0;
            tx_shift <= 10'h3FF;
            LIN_OUT  <= 1'b0;
            LIN_OE_N <= 1'b1;
        end else begin
            LIN_OUT <= 1'b0;
            case (tx_state)
                TX_IDLE: begin
                    LIN_OE_N <= 1'b1;
                    if (tx_load) begin
                        tx_shift <= {1'b1, tx_hold, 1'b0};
                        tx_cnt   <= 16'(BIT_CYCLES - 1);
                        tx_bits  <= 4'(`FRAME_BITS - 1);
                        LIN_OE_N <= 1'b0;
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (coll_abort || break_hit) begin
                        LIN_OE_N <= 1'b1;
                        tx_state <= TX_IDLE;
                    end else if (tx_cnt == 16'h0) begin
                        if (tx_bits == 4'h0) begin
                            LIN_OE_N <= 1'b1;
                            tx_state <= TX_IDLE;
                        end else begin
                            tx_shift <= {1'b1, tx_shift[9:1]};
                            tx_bits  <= tx_bits - 4'h1;
                            tx_cnt   <= 16'(BIT_CYCLES - 1);
                            LIN_OE_N <= tx_shift[1];
                        end
                    end else
                        tx_cnt <= tx_cnt - 16'h1;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

endmodule

// [sim/lin_flags_props.sv]
// assertions on the ports of the link status block
`timescale 1ns/10ps
module lin_flags_props #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic                   CORE_CLK,
    input wire logic                   NRST,
    input wire logic                   AWVALID,
    input wire logic                   AWREADY,
    input wire logic                   BVALID,
    input wire logic                   BREADY,
    input wire logic [1:0]             BRESP,
    input wire logic                   ARVALID,
    input wire logic                   ARREADY,
    input wire logic                   RVALID,
    input wire logic                   RREADY,
    input wire logic [31:0]            RDATA,
    input wire logic                   LIN_IN,
    input wire logic                   LIN_OE_N,
    input wire logic                   IRQ,
    input wire lin_flags_pkg::status_t STATUS_FLAGS
);
    import lin_flags_pkg::*;
    logic [15:0] low_cnt;
    logic        busy;
    // bus traffic that may legally clear sticky flags
    assign busy = ARVALID || !ARREADY || AWVALID || !AWREADY;
    // length of the current low phase on the bus
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) low_cnt <= 16'h0000;
        else if (LIN_IN) low_cnt <= 16'h0000;
        else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    sequence long_low_s;
        !LIN_IN && (low_cnt == 16'(11 * BIT_CYCLES));
    endsequence
    brk_detect_a: assert property (long_low_s |-> ##[1:8] STATUS_FLAGS.brk)
        else $error("break flag missing after long low");
    frame_sticky_a: assert property ($fell(STATUS_FLAGS.frame_err) |-> $past(busy))
        else $error("frame flag dropped without access");
    edge_sticky_a: assert property ($fell(STATUS_FLAGS.edge_err) |-> $past(busy))
        else $error("edge flag dropped without access");
    coll_sticky_a: assert property ($fell(STATUS_FLAGS.collision) |-> $past(busy))
        else $error("collision flag dropped without access");
    brk_sticky_a: assert property ($fell(STATUS_FLAGS.brk) |-> $past(busy))
        else $error("break flag dropped without access");
    txrdy_load_a: assert property ($rose(STATUS_FLAGS.tx_ready) |-> $fell(LIN_OE_N))
        else $error("transmit ready rose without a load");
    txdone_busy_a: assert property (!LIN_OE_N |-> !STATUS_FLAGS.tx_done)
        else $error("transmit complete while driving");
    irq_quiet_a: assert property (STATUS_FLAGS == 7'h00 |-> !IRQ)
        else $error("interrupt with no status bit");
    bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response not held");
    rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data not held");
endmodule

bind lin_slave_status_flags lin_flags_props #(.BIT_CYCLES(BIT_CYCLES)) props (
    .CORE_CLK, .NRST, .AWVALID, .AWREADY, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
    .RVALID, .RREADY, .RDATA, .LIN_IN, .LIN_OE_N, .IRQ, .STATUS_FLAGS
);

// [sim/lin_master_model.sv]
// behavioural master node on the single-wire bus
`timescale 1ns/10ps
module lin_master_model #(
    parameter int BIT = 16
) (
    input  wire logic clk,
    input  wire logic oe_n,
    output logic      bus
);
    logic drv = 1'b1;
    // wired-and with pull-up: either node may pull low
    assign bus = drv & oe_n;
    // one frame: start, data lsb first, stop, one idle bit
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            drv <= f[i];
            repeat (BIT) @(posedge clk);
        end
        drv <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask
    // bus held dominant for n cycles
    task automatic hold(input int n);
        @(posedge clk);
        drv <= 1'b0;
        repeat (n) @(posedge clk);
        drv <= 1'b1;
    endtask
    // byte sent by the slave, sampled mid bit
    task automatic get(output logic [7:0] b, output logic ok);
        ok = 1'b0;
        b = 8'h00;
        for (int n = 0; n < 4000 && !ok; n++) begin
            @(posedge clk);
            ok = !bus;
        end
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b = {bus, b[7:1]};
        end
        repeat (BIT) @(posedge clk);
    endtask
endmodule

// [sim/lin_slave_status_flags_tb.sv]
// self-checking bench for the link status block
`timescale 1ns/10ps
`include "lin_flags_map.svh"
module lin_slave_status_flags_tb;
    import lin_flags_pkg::*;
    localparam int          B     = 16;
    localparam logic [4:0]  WAFER = 5'h0C;     // arbitrary value
    localparam logic [4:0]  PLANT = 5'h15;     // arbitrary value
    localparam logic [21:0] LOT   = 22'h2A5C3; // arbitrary value
    localparam logic [3:0]  MREV  = 4'hB;      // arbitrary value
    localparam logic [7:0]  KREV  = 8'h43;     // arbitrary value
    localparam logic [15:0] PART  = 16'h7E21;  // arbitrary value
    localparam logic [3:0]  FAM   = 4'h5;      // arbitrary value
    logic        CORE_CLK = 1'b0;
    logic        NRST = 1'b0;
    logic [31:0] AWADDR = 32'h0;
    logic [31:0] WDATA = 32'h0;
    logic [31:0] ARADDR = 32'h0;
    logic [3:0]  WSTRB = 4'hF;
    logic        AWVALID = 1'b0;
    logic        WVALID = 1'b0;
    logic        BREADY = 1'b0;
    logic        ARVALID = 1'b0;
    logic        RREADY = 1'b0;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, LIN_IN, LIN_OUT, LIN_OE_N, IRQ;
    logic [1:0]  BRESP, RRESP, resp;
    logic [31:0] RDATA, rd_val;
    status_t     STATUS_FLAGS;
    logic [7:0]  rx_byte;
    logic        rx_ok;
    int          n_errors = 0;
    int          comparisons = 0;
    // 100 MHz core clock
    initial begin
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    lin_slave_status_flags #(
        .BIT_CYCLES(B), .WAFER_NUM(WAFER), .FAB_PLANT(PLANT), .LOT_ID(LOT),
        .MASK_REV(MREV), .KERNEL_REV(KREV), .PART_ID(PART), .FAMILY_ID(FAM)
    ) uut (
        .CORE_CLK, .NRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
        .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
        .RREADY, .LIN_IN, .LIN_OUT, .LIN_OE_N, .IRQ, .STATUS_FLAGS
    );
    lin_master_model #(.BIT(B)) m (.clk(CORE_CLK), .oe_n(LIN_OE_N), .bus(LIN_IN));
    // compare, count, report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // counts, verdict, end of run
    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    // write: address and data offered together, each released when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge CORE_CLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CORE_CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID) break;
        end
        chk("bvalid", 32'(n < 50), 32'h1);
        if (n == 50) finish_test();
        resp = BRESP;
        BREADY <= 1'b0;
    endtask
    // read: data taken at the handshake edge
    task automatic rd(input logic [31:0] a);
        int n;
        @(posedge CORE_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge CORE_CLK);
            if (ARREADY) ARVALID <= 1'b0;
            if (RVALID) break;
        end
        chk("rvalid", 32'(n < 50), 32'h1);
        if (n == 50) finish_test();
        rd_val = RDATA;
        resp = RRESP;
        RREADY <= 1'b0;
    endtask
    task automatic rc(input string what, input logic [31:0] a, input logic [31:0] exp);
        rd(a);
        chk(what, rd_val, exp);
    endtask
    // main sequence
    initial begin
        cyc(8);
        NRST <= 1'b1;
        cyc(2);
        // reset state, identity words, flash address
        chk("flags", 32'(STATUS_FLAGS), 32'h2);
        chk("irq", 32'(IRQ), 32'h0);
        chk("lin out", 32'(LIN_OUT), 32'h0);
        rc("status", `ADDR_STATUS, 32'h2);
        rc("mask", `ADDR_MASK, 32'h7F);
        rc("lot", `ADDR_LOT_TRACE, {WAFER, PLANT, LOT});
        rc("rev", `ADDR_REV_TRACE, {MREV, KREV, 4'h0, PART});
        rc("flash", `ADDR_FLASH_ADDR, {28'h0, FAM});
        wr(`ADDR_FLASH_ADDR, 32'hFFFFABCD);
        chk("bresp", 32'(resp), 32'h0);
        rc("flash rw", `ADDR_FLASH_ADDR, 32'hABCD);
        chk("rresp", 32'(resp), 32'h0);
        WSTRB <= 4'h1;
        wr(`ADDR_FLASH_ADDR, 32'h00001234);
        WSTRB <= 4'hF;
        rc("flash strobe", `ADDR_FLASH_ADDR, 32'hAB34);
        rc("unmapped", 32'hFFFF0800, 32'h0);
        chk("slverr", 32'(resp), 32'h2);
        wr(32'hFFFF0800, 32'h1);
        chk("bresp err", 32'(resp), 32'h2);
        // pending byte replaced, then sent in transmit mode
        wr(`ADDR_DATA, 32'h11);
        wr(`ADDR_DATA, 32'h3C);
        cyc(2);
        chk("pending", 32'(STATUS_FLAGS[2:1]), 32'h0);
        fork
            wr(`ADDR_CONTROL, 32'h1);
            m.get(rx_byte, rx_ok);
        join
        chk("tx start", 32'(rx_ok), 32'h1);
        chk("tx byte", 32'(rx_byte), 32'h3C);
        cyc(2 * B);
        chk("tx end", 32'(STATUS_FLAGS[2:1]), 32'h3);
        // master holds the bus dominant under a recessive bit
        fork
            m.hold(3 * B);
            wr(`ADDR_DATA, 32'h01);
        join
        cyc(2 * B);
        rd(`ADDR_STATUS);
        chk("collision", 32'(rd_val[4]), 32'h1);
        rd(`ADDR_STATUS);
        chk("coll clear", 32'(rd_val[4]), 32'h0);
        // break with its interrupt unmasked, cleared by writing one
        wr(`ADDR_MASK, 32'h77);
        cyc(2);
        chk("irq masked", 32'(IRQ), 32'h0);
        m.hold(12 * B);
        cyc(2 * B);
        chk("brk", 32'(STATUS_FLAGS.brk), 32'h1);
        chk("irq", 32'(IRQ), 32'h1);
        rc("mode", `ADDR_CONTROL, 32'h0);
        wr(`ADDR_STATUS, 32'h8);
        cyc(2);
        chk("irq clear", 32'(IRQ), 32'h0);
        chk("brk clear", 32'(STATUS_FLAGS.brk), 32'h0);
        wr(`ADDR_MASK, 32'h7F);
        // 56 then 57 falling edges since the break
        repeat (11) m.send(8'h55, 1'b1);
        m.send(8'hFF, 1'b1);
        cyc(4);
        chk("edges 56", 32'(STATUS_FLAGS.edge_err), 32'h0);
        m.send(8'hFF, 1'b1);
        cyc(4);
        chk("edges 57", 32'(STATUS_FLAGS.edge_err), 32'h1);
        rd(`ADDR_STATUS);
        chk("edge flag", 32'(rd_val[5]), 32'h1);
        rd(`ADDR_STATUS);
        chk("edge clear", 32'(rd_val[6:3]), 32'h0);
        chk("rx ready", 32'(STATUS_FLAGS.rx_ready), 32'h1);
        rc("rx data", `ADDR_DATA, 32'hFF);
        cyc(2);
        chk("rx taken", 32'(STATUS_FLAGS.rx_ready), 32'h0);
        // byte with a low stop bit
        m.send(8'hF0, 1'b0);
        cyc(4);
        rd(`ADDR_STATUS);
        chk("frame err", 32'(rd_val[6]), 32'h1);
        rd(`ADDR_STATUS);
        chk("frame clear", 32'(rd_val[6]), 32'h0);
        finish_test();
    end
endmodule
